// *** rtl/serial_unit_pkg.sv ***
package serial_unit_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] status_addr = 8'h00;
    localparam logic [7:0] control_addr = 8'h04;
    localparam logic [7:0] pins_addr = 8'h08;
    localparam logic [7:0] data_addr = 8'h0c;
    localparam logic [7:0] global_addr = 8'h10;
    // status fields
    localparam int start_bit = 7;
    localparam int ovf_bit = 6;
    localparam int stop_bit = 5;
    localparam int coll_bit = 4;
    localparam int cnt_msb = 3;
    // control fields
    localparam int sie_bit = 7;
    localparam int oie_bit = 6;
    localparam int wm_msb = 5;
    localparam int wm_lsb = 4;
    localparam int cs_msb = 3;
    localparam int cs_lsb = 2;
    localparam int clk_bit = 1;
    localparam int tgl_bit = 0;
    // pins register: port bits low, direction bits high
    localparam int port_lsb = 0;
    localparam int ddr_lsb = 4;
    localparam int gie_bit = 0;
    // pin index inside port and direction groups
    localparam int pin_do = 0;
    localparam int pin_sda = 1;
    localparam int pin_scl = 2;
    localparam int npins = 3;
    // wire modes and clock sources
    localparam logic [1:0] wm_none = 2'h0;
    localparam logic [1:0] wm_three = 2'h1;
    localparam logic [1:0] wm_two_hold = 2'h3;
    localparam logic [1:0] cs_soft = 2'h0;
    localparam logic [1:0] cs_timer = 2'h1;
    localparam logic [1:0] cs_ext_pos = 2'h2;
    localparam logic [3:0] cnt_max = 4'hf;
    localparam logic [7:0] reset_byte = 8'h00;
    localparam logic [2:0] reset_pins = 3'h0;
endpackage

// *** rtl/serial_unit_status_control.sv ***
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - two-wire start condition sets start flag
// - other modes: counter increment sets start flag
// - start irq when flag, enable, global set
// - write one clears start flag, releases hold
// - start irq wakes from any sleep
// - counter wrap 15 to 0 sets overflow
// - overflow irq when flag, enable, global set
// - write one clears overflow, releases hold
// - overflow irq wakes from idle only
// - two-wire stop sets stop flag, no irq
// - collision bit: shift msb differs from pin
// - counter readable and writable in status
// - counter increments on selected clock source
// - external source plus strobe: toggle clocks counter
// - external clock drives counter in every mode
// - pending flag interrupts once enabled
// - wire mode changes outputs and the start and stop flag sources
// - mode none: pins behave as port pins
// - three-wire: shift msb replaces port bit
// - two-wire data pulled low, pull-ups off
// - two-wire clock low, held after start
// - two-wire mode 11 also holds clock after overflow
// - soft source: strobe shifts and counts
module serial_unit_status_control
    import serial_unit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_match,
    input wire logic sleep_idle,
    input wire logic serial_in_pin,
    input wire logic serial_clock_pin,
    output logic irq_start,
    output logic irq_overflow,
    output logic wake_req,
    output logic data_out,
    output logic data_oe_n,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_out,
    output logic scl_oe_n,
    output logic [2:0] pullup_en
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic sda_s1, sda_s2, sda_d;
        logic scl_s1, scl_s2, scl_d;
        logic start_f, ovf_f, stop_f, start_hold, ovf_hold;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic sie, oie, gie, clk_sel;
        logic [1:0] wm, cs;
        logic [2:0] port, ddr;
        logic [31:0] rdata;
        logic err, rdy, irq_s, irq_o, wake;
        logic dout, doe_n, sout, soe_n, cout, coe_n;
        logic [2:0] pu;
    } state_t;

    state_t r, n;
    logic wr, rd_setup, wr_stat, wr_ctrl, wr_data;
    logic [1:0] cs_e;
    logic clk_sel_e, strobe, toggle, inc, shift_clk;
    logic scl_rise, scl_fall, scl_edge, start_det, stop_det;
    logic wrap, two_wire, clr_start, clr_ovf;
    logic [7:0] stat_rd;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        wr = psel && penable && pwrite;
        rd_setup = psel && !penable;
        wr_stat = wr && paddr == status_addr;
        wr_ctrl = wr && paddr == control_addr;
        wr_data = wr && paddr == data_addr;
        two_wire = r.wm[1];
        // pins pass two flops; only the second and later are read
        n.sda_s1 = serial_in_pin;
        n.sda_s2 = r.sda_s1;
        n.sda_d = r.sda_s2;
        n.scl_s1 = serial_clock_pin;
        n.scl_s2 = r.scl_s1;
        n.scl_d = r.scl_s2;
        scl_rise = r.scl_s2 && !r.scl_d;
        scl_fall = !r.scl_s2 && r.scl_d;
        scl_edge = scl_rise || scl_fall;
        // bus conditions: data moves while clock stays high
        start_det = !r.sda_s2 && r.sda_d && r.scl_s2 && r.scl_d;
        stop_det = r.sda_s2 && !r.sda_d && r.scl_s2 && r.scl_d;
        // strobes use the source being written with them
        cs_e = wr_ctrl ? pwdata[cs_msb:cs_lsb] : r.cs;
        clk_sel_e = wr_ctrl ? pwdata[clk_bit] : r.clk_sel;
        strobe = wr_ctrl && pwdata[clk_bit];
        toggle = wr_ctrl && pwdata[tgl_bit];
        // counter clock; scl is sampled in every wire mode
        case (cs_e)
            cs_soft: inc = strobe;
            cs_timer: inc = timer_match;
            default: inc = clk_sel_e ? toggle : scl_edge;
        endcase
        // shift clock: external sources use one edge only
        case (cs_e)
            cs_soft: shift_clk = strobe;
            cs_timer: shift_clk = timer_match;
            cs_ext_pos: shift_clk = scl_rise;
            default: shift_clk = scl_fall;
        endcase
        wrap = inc && r.cnt == cnt_max;
        // a cpu write to the counter wins over a count
        if (wr_stat) begin
            n.cnt = pwdata[cnt_msb:0];
        end else if (inc) begin
            n.cnt = r.cnt + 4'h1;
        end
        // a cpu write to the shift register wins over a shift
        if (wr_data) begin
            n.shift = pwdata[7:0];
        end else if (shift_clk) begin
            n.shift = {r.shift[6:0], r.sda_s2};
        end
        // flags: hardware set wins over the clearing write
        clr_start = wr_stat && pwdata[start_bit];
        clr_ovf = wr_stat && pwdata[ovf_bit];
        n.start_f = (r.start_f && !clr_start)
            || (two_wire ? start_det : inc);
        n.ovf_f = (r.ovf_f && !clr_ovf) || wrap;
        n.stop_f = (r.stop_f && !(wr_stat && pwdata[stop_bit]))
            || (two_wire && stop_det);
        // clock holds live only in two-wire modes
        n.start_hold = two_wire && n.start_f
            && (r.start_hold || scl_fall);
        n.ovf_hold = r.wm == wm_two_hold && n.ovf_f
            && (r.ovf_hold || wrap);
        // control and local registers
        if (wr_ctrl) begin
            n.sie = pwdata[sie_bit];
            n.oie = pwdata[oie_bit];
            n.wm = pwdata[wm_msb:wm_lsb];
            n.cs = pwdata[cs_msb:cs_lsb];
            n.clk_sel = pwdata[clk_bit];
        end
        if (wr && paddr == pins_addr) begin
            n.port = pwdata[port_lsb +: npins];
            n.ddr = pwdata[ddr_lsb +: npins];
        end
        // toggle flips the clock port bit whatever the mode
        if (toggle) begin
            n.port[pin_scl] = !n.port[pin_scl];
        end
        if (wr && paddr == global_addr) begin
            n.gie = pwdata[gie_bit];
        end
        // status read; strobe bits read as zero
        stat_rd = {r.start_f, r.ovf_f, r.stop_f,
            r.shift[7] != r.sda_s2, r.cnt};
        // read data is latched in setup, so zero wait states
        n.rdy = 1'b1;
        if (rd_setup) begin
            n.err = 1'b0;
            case (paddr)
                status_addr: n.rdata = {24'h0, stat_rd};
                control_addr: n.rdata = {24'h0, r.sie, r.oie, r.wm,
                    r.cs, 2'h0};
                pins_addr: n.rdata = {25'h0, r.ddr, 1'b0, r.port};
                data_addr: n.rdata = {24'h0, r.shift};
                global_addr: n.rdata = {31'h0, r.gie};
                default: begin
                    n.rdata = 32'h0;
                    n.err = 1'b1;
                end
            endcase
        end
        // interrupt levels follow flags, so pending ones fire at once
        n.irq_s = r.start_f && r.sie && r.gie;
        n.irq_o = r.ovf_f && r.oie && r.gie;
        n.wake = n.irq_s || (n.irq_o && sleep_idle);
        // pins: wire mode touches only the output side
        n.dout = r.port[pin_do];
        n.doe_n = !r.ddr[pin_do];
        n.sout = r.port[pin_sda];
        n.soe_n = !r.ddr[pin_sda];
        n.cout = r.port[pin_scl];
        n.coe_n = !r.ddr[pin_scl];
        n.pu = r.port & ~r.ddr;
        if (r.wm == wm_three) begin
            n.dout = r.shift[7];
        end else if (two_wire) begin
            // open drain: drive low or release
            n.sout = 1'b0;
            n.soe_n = !(r.ddr[pin_sda]
                && (!r.shift[7] || !r.port[pin_sda]));
            n.cout = 1'b0;
            n.coe_n = !(r.ddr[pin_scl] && (!r.port[pin_scl]
                || r.start_hold || r.ovf_hold));
            n.pu = reset_pins;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.sda_s1 <= 1'b1;
            r.sda_s2 <= 1'b1;
            r.sda_d <= 1'b1;
            r.scl_s1 <= 1'b1;
            r.scl_s2 <= 1'b1;
            r.scl_d <= 1'b1;
            r.doe_n <= 1'b1;
            r.soe_n <= 1'b1;
            r.coe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // outputs straight from flops
    assign prdata = r.rdata;
    assign pready = r.rdy;
    assign pslverr = r.err;
    assign irq_start = r.irq_s;
    assign irq_overflow = r.irq_o;
    assign wake_req = r.wake;
    assign data_out = r.dout;
    assign data_oe_n = r.doe_n;
    assign sda_out = r.sout;
    assign sda_oe_n = r.soe_n;
    assign scl_out = r.cout;
    assign scl_oe_n = r.coe_n;
    assign pullup_en = r.pu;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_start_two_wire: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.wm[1] && start_det |=> r.start_f)
        else $error("start condition did not set flag");
    a_start_on_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        !r.wm[1] && inc |=> r.start_f)
        else $error("count did not set start flag");
    a_start_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_start == $past(r.start_f && r.sie && r.gie))
        else $error("start irq does not follow flag");
    a_start_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.start_f && !clr_start |=> r.start_f)
        else $error("start flag lost without clear");
    a_ovf_wrap: assert property (
        @(posedge pclk) disable iff (!presetn)
        inc && !wr_stat && r.cnt == cnt_max |=> r.ovf_f && r.cnt == '0)
        else $error("wrap did not set overflow");
    a_ovf_wake_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        wake_req && !irq_start |-> irq_overflow && $past(sleep_idle))
        else $error("wake without pending irq");
    a_stop_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.wm[1] && stop_det |=> r.stop_f)
        else $error("stop flag not set");
    a_cnt_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_stat |=> r.cnt == $past(pwdata[cnt_msb:0]))
        else $error("counter write lost");
    a_scl_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.wm[1] && r.ddr[pin_scl] && r.start_hold |=> !scl_oe_n && !scl_out)
        else $error("clock not held after start");
    a_pullup_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.wm[1] |=> pullup_en == 3'h0)
        else $error("pull-ups on in two-wire mode");
    // flag clearing, interrupt and wake levels
    a_start_release: assert property (
        @(posedge pclk) disable iff (!presetn)
        clr_start && !(two_wire ? start_det : inc) |=> !r.start_f)
        else $error("start flag kept after clear");
    a_ovf_keep: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.ovf_f && !clr_ovf |=> r.ovf_f)
        else $error("overflow flag lost without clear");
    a_ovf_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_overflow == $past(r.ovf_f && r.oie && r.gie))
        else $error("overflow irq does not follow flag");
    a_irq_from_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_start || irq_overflow |-> $past(r.start_f || r.ovf_f))
        else $error("irq without start or overflow flag");
    a_wake_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_start |-> wake_req)
        else $error("start irq did not request wake");
    // counter clock paths
    a_soft_strobe: assert property (
        @(posedge pclk) disable iff (!presetn)
        cs_e == cs_soft && strobe |=> r.cnt == $past(r.cnt) + 4'h1)
        else $error("soft strobe did not count");
    a_scl_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        cs_e == cs_ext_pos && !clk_sel_e && scl_edge && !wr_stat
            |=> r.cnt == $past(r.cnt) + 4'h1)
        else $error("clock pin edge did not count");
    a_toggle_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        cs_e != cs_soft && cs_e != cs_timer && clk_sel_e |-> inc == toggle)
        else $error("counter not clocked by toggle strobe");
    // pin drive in each wire mode
    a_mode_none_pins: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.wm == wm_none |=> scl_oe_n == !$past(r.ddr[pin_scl])
            && sda_out == $past(r.port[pin_sda]))
        else $error("port pins not plain in mode none");
    a_three_wire_out: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.wm == wm_three |=> data_out == $past(r.shift[7])
            && data_oe_n == !$past(r.ddr[pin_do]))
        else $error("data out not from shift msb");
    a_sda_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        two_wire && r.ddr[pin_sda] && !r.shift[7] |=> !sda_oe_n && !sda_out)
        else $error("data line not pulled low");
    a_ovf_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.wm == wm_two_hold && r.ddr[pin_scl] && r.ovf_hold |=> !scl_oe_n && !scl_out)
        else $error("clock not held after overflow");
endmodule

// *** verif/wire_master.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-wire master at the far side of the bus
// ------------------------------------------------------------
module wire_master (
    input wire logic pclk,
    input wire logic sda_oe_n,
    input wire logic sda_out,
    input wire logic scl_oe_n,
    input wire logic scl_out,
    output logic sda_line,
    output logic scl_line
);
    logic m_sda = 1'b1;
    logic m_scl = 1'b1;
    // open drain with pull-up: any party pulling low wins
    assign sda_line = m_sda & (sda_oe_n | sda_out);
    assign scl_line = m_scl & (scl_oe_n | scl_out);
    // one half period of the 400 ns link clock is five pclk
    task automatic drive(input logic sda, input logic scl);
        @(posedge pclk);
        m_sda <= sda;
        m_scl <= scl;
        repeat (4) @(posedge pclk);
    endtask
    // a released clock may still be held low by the slave
    task automatic wait_scl_high();
        for (int i = 0; i < 16 && scl_line !== 1'b1; i++) @(posedge pclk);
    endtask
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import serial_unit_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, err, timer_match = 0, sleep_idle = 0, sda_line, scl_line;
    logic irq_start, irq_overflow, wake_req, data_out, data_oe_n;
    logic sda_out, sda_oe_n, scl_out, scl_oe_n;
    logic [2:0] pullup_en;
    int miscompares = 0, total_checks = 0, cycles = 0;
    // write then read back; the last row is unmapped
    row_t rows [7] = '{'{8'h0c, 8'hff, 8'hff, 0}, '{8'h08, 8'h77, 8'h77, 0},
        '{8'h10, 8'h01, 8'h01, 0}, '{8'h00, 8'h0e, 8'h0e, 0}, '{8'h04, 8'h30, 8'h30, 0},
        '{8'h04, 8'h00, 8'h00, 0}, '{8'h14, 8'h55, 8'h00, 1}};
    always #20 pclk = ~pclk;
    serial_unit_status_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_match(timer_match),
        .sleep_idle(sleep_idle), .serial_in_pin(sda_line), .serial_clock_pin(scl_line),
        .irq_start(irq_start), .irq_overflow(irq_overflow), .wake_req(wake_req),
        .data_out(data_out), .data_oe_n(data_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .pullup_en(pullup_en));
    wire_master u_master (.pclk(pclk), .sda_oe_n(sda_oe_n), .sda_out(sda_out),
        .scl_oe_n(scl_oe_n), .scl_out(scl_out), .sda_line(sda_line), .scl_line(scl_line));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] q);
        apb(0, a, 8'h00);
        check("read data", r, {24'h0, q});
    endtask
    task automatic conclude();
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // bound on the whole run; a hang is counted as a mismatch
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        check("released scl", scl_oe_n, 1'b1);
        rd(status_addr, 8'h10);
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].q);
            check("slave error", err, rows[i].e);
        end
        // two soft strobes wrap 14 to 0
        apb(1, control_addr, 8'h02);
        apb(1, control_addr, 8'h02);
        rd(status_addr, 8'hc0);
        apb(1, control_addr, 8'h40);
        repeat (2) @(posedge pclk);
        check("overflow irq", irq_overflow, 1'b1);
        check("wake busy", wake_req, 1'b0);
        sleep_idle <= 1;
        repeat (2) @(posedge pclk);
        check("wake idle", wake_req, 1'b1);
        sleep_idle <= 0;
        apb(1, control_addr, 8'hc0);
        repeat (2) @(posedge pclk);
        check("start irq wake", {irq_start, wake_req}, 2'b11);
        apb(1, status_addr, 8'hc0);
        rd(status_addr, 8'h00);
        check("irqs cleared", {irq_start, irq_overflow}, 2'b00);
        // timer match, then both scl edges, then toggle strobe
        apb(1, control_addr, 8'h04);
        @(posedge pclk) timer_match <= 1;
        @(posedge pclk) timer_match <= 0;
        rd(status_addr, 8'h81);
        apb(1, control_addr, 8'h08);
        u_master.drive(1, 0);
        u_master.drive(1, 1);
        rd(status_addr, 8'h83);
        apb(1, control_addr, 8'h0b);
        rd(status_addr, 8'h84);
        apb(1, pins_addr, 8'h77);
        // two-wire start, clock hold and stop
        apb(1, control_addr, 8'h20);
        apb(1, status_addr, 8'he0);
        check("pull-ups", pullup_en[2:1], 2'b00);
        u_master.drive(0, 1);
        u_master.drive(0, 0);
        rd(status_addr, 8'h90);
        check("scl hold", scl_oe_n, 1'b0);
        u_master.drive(0, 1);
        check("scl line held", scl_line, 1'b0);
        apb(1, status_addr, 8'h80);
        u_master.wait_scl_high();
        check("scl line free", scl_line, 1'b1);
        u_master.drive(1, 1);
        rd(status_addr, 8'h20);
        // mode 11: overflow holds the clock
        apb(1, status_addr, 8'h2f);
        apb(1, control_addr, 8'h30);
        apb(1, control_addr, 8'h32);
        repeat (3) @(posedge pclk);
        check("overflow hold", scl_oe_n, 1'b0);
        rd(status_addr, 8'h40);
        apb(1, status_addr, 8'h40);
        repeat (3) @(posedge pclk);
        check("hold freed", scl_oe_n, 1'b1);
        // shift msb low pulls the data line, then restore it
        apb(1, data_addr, 8'h7f);
        repeat (2) @(posedge pclk);
        check("sda pulled low", {sda_oe_n, sda_out, sda_line}, 3'h0);
        apb(1, data_addr, 8'hff);
        // three-wire: shift msb drives the data-out pin
        apb(1, control_addr, 8'h10);
        repeat (2) @(posedge pclk);
        check("data out", {data_oe_n, data_out}, 2'b01);
        // input pins in three-wire: port bits set the pull-ups
        apb(1, pins_addr, 8'h07);
        repeat (2) @(posedge pclk);
        check("port pull-ups", {pullup_en, data_oe_n}, 4'hf);
        // mid-run reset: pins released, status back to idle
        presetn <= 0;
        @(posedge pclk);
        check("reset outputs", {pready, pullup_en, data_oe_n, sda_oe_n, scl_oe_n}, 7'h07);
        presetn <= 1;
        rd(status_addr, 8'h10);
        conclude();
    end
endmodule
